// *** design/adp_framer.sv ***
/*
 * Serial frame transmitter with forwarded bit clock and frame clock.
 * Assumes i_word is stable in the cycle that i_start is taken.
 */
module adp_framer
	import adp_pkg::*;
(
	input wire logic i_clk, // System clock
	input wire logic i_rst_b, // Async reset, active low
	input wire logic i_start, // Start one transfer, pulse
	input wire logic i_ddc, // Two frames: in-phase then quadrature
	input wire logic i_w24, // 24-bit frames, else 20-bit
	input wire logic i_sdr, // One bit per bit-clock period
	input wire logic [47:0] i_word, // Word to send, MSB first
	output logic o_dclk, // Forwarded bit clock
	output logic o_dout, // Serial data
	output logic o_fclk, // Frame clock
	output logic o_busy // Transfer in progress
);
	typedef struct packed {
		logic busy;
		logic half;
		logic dclk;
		logic dout;
		logic fclk;
		logic frm;
		logic w24;
		logic sdr;
		logic [4:0] bitc;
		logic [47:0] sh;
	} adp_frm_t;

	adp_frm_t q;
	adp_frm_t next_q;

	// ----------------------------------------
	// Bit sequencing
	// ----------------------------------------
	always_comb begin
		logic [4:0] w;
		logic step;
		next_q = q;
		step = 1'b0;
		w = q.w24 ? FRAME_W24 : FRAME_W20;
		if (!q.busy) begin
			next_q.dclk = 1'b0;
			next_q.dout = 1'b0;
			next_q.fclk = 1'b0;
			next_q.half = 1'b0;
			if (i_start) begin
				next_q.busy = 1'b1;
				next_q.bitc = '0;
				next_q.frm = i_ddc;
				next_q.w24 = i_w24;
				next_q.sdr = i_sdr;
				// Narrow frames keep the top bits of each half
				if (i_ddc && !i_w24) begin
					next_q.sh = {i_word[47:28], i_word[23:4], 8'h00};
				end else begin
					next_q.sh = i_word;
				end
			end
		end else if (q.sdr && q.half) begin
			next_q.dclk = 1'b1; // Rising edge mid-bit
			next_q.half = 1'b0;
			step = 1'b1;
		end else begin
			next_q.dout = q.sh[47];
			next_q.fclk = (q.bitc < (w >> 1));
			if (q.sdr) begin
				next_q.dclk = 1'b0;
				next_q.half = 1'b1;
			end else begin
				next_q.dclk = ~q.dclk; // Both edges carry data
				step = 1'b1;
			end
		end
		if (step) begin
			next_q.sh = {q.sh[46:0], 1'b0};
			if (q.bitc == w - 5'h01) begin
				next_q.bitc = '0;
				if (q.frm) begin
					next_q.frm = 1'b0;
				end else begin
					next_q.busy = 1'b0;
				end
			end else begin
				next_q.bitc = q.bitc + 5'h01;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign o_dclk = q.dclk;
	assign o_dout = q.dout;
	assign o_fclk = q.fclk;
	assign o_busy = q.busy;
endmodule

// *** design/adp_sync2.sv ***
/*
 * Two-flop synchroniser for a group of independent levels.
 * Assumes each bit is a level that may change at any time.
 */
module adp_sync2 #(
	parameter int W = 1
) (
	input wire logic i_clk, // Destination clock
	input wire logic i_rst_b, // Async reset, active low
	input wire logic [W-1:0] i_d, // Levels from another domain
	output logic [W-1:0] o_q // Synchronised levels
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} adp_sync_t;

	adp_sync_t q;
	adp_sync_t next_q;

	// ----------------------------------------
	// Two stages, first read only by second
	// ----------------------------------------
	always_comb begin
		next_q.s1 = i_d;
		next_q.s2 = q.s1;
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign o_q = q.s2;
endmodule

// *** design/adp_top.sv ***
/*
 * Converter output datapath: configuration port and register file,
 * sample formatting, averaging filter, mixer with oscillator, and the
 * serial output link. Assumes the sampling clock is free running and
 * that the conversion code arrives in offset binary, valid at its
 * falling edge.
 */
module adp_top
	import adp_pkg::*;
(
	input wire logic i_clk, // System clock
	input wire logic i_rst_b, // Async reset, active low
	input wire logic i_smpl_clk, // Sampling clock
	input wire logic i_sync_pulse_in, // Sync, sampling clock domain
	input wire logic [15:0] i_adc_code, // Conversion code, offset binary
	input wire logic [9:0] i_temp_code, // Temperature sensor level
	input wire logic i_cs_b, // Config port select, active low
	input wire logic i_sclk, // Config port clock
	input wire logic i_sdi, // Config port data in
	output logic o_sdo, // Config port data out
	output logic o_sdo_oe, // Data out enable, high when driving
	output logic o_dclk, // Link bit clock
	output logic o_dout, // Link data
	output logic o_fclk, // Link frame clock
	output logic o_internal_ref_off // Internal reference disabled
);
	typedef struct packed {
		logic [15:0][15:0] rf;
		logic sclk_d;
		logic [4:0] bitc;
		logic [22:0] sh;
		logic [15:0] rd_sh;
		logic rd_act;
		logic sdo;
		logic sdo_oe;
		logic cfg_tog;
		logic wtog_d;
		logic ref_off;
	} adp_cfg_t;

	typedef struct packed {
		logic cfg_s1;
		logic cfg_s2;
		logic cfg_d;
		logic twos;
		logic avg_en;
		logic ddc_en;
		logic [1:0] ratio;
		logic [23:0] freq;
		logic [23:0] phase0;
		logic [23:0] ph;
		logic sync_d;
		logic [3:0] cnt;
		logic signed [27:0] acc_i;
		logic signed [27:0] acc_q;
		logic [47:0] word;
		logic ddc_w;
		logic wtog;
	} adp_smp_t;

	adp_cfg_t q;
	adp_cfg_t next_q;
	adp_smp_t s;
	adp_smp_t next_s;
	logic [SYNC_W-1:0] sync_q;
	logic sclk_s;
	logic cs_s;
	logic sdi_s;
	logic wtog_s;
	logic [9:0] temp_s;
	logic frm_busy;
	logic frm_start;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Address decode, {valid, index}
	function automatic logic [4:0] dec(input logic [7:0] a,
			input logic bank1);
		logic [4:0] r;
		logic b1;
		r = '0;
		b1 = 1'b1;
		case (a)
			A_RDEN: r = {1'b1, I_RDEN};
			A_BANK: r = {1'b1, I_BANK};
			A_INIT: r = {1'b1, I_INIT};
			A_LANE: r = {1'b1, I_LANE};
			A_LCF: r = {1'b1, I_LCF};
			A_FMT: r = {bank1, I_FMT};
			A_TCTL: r = {bank1, I_TCTL};
			A_TRES: r = {bank1, I_TRES};
			A_PWR: r = {bank1, I_PWR};
			A_REF: r = {bank1, I_REF};
			A_DINIT: r = {bank1, I_DINIT};
			A_LCC: r = {bank1, I_LCC};
			A_LCE: r = {bank1, I_LCE};
			A_PHL: r = {bank1, I_PHL};
			A_PFS: r = {bank1, I_PFS};
			A_FRH: r = {bank1, I_FRH};
			default: r = '0;
		endcase
		dec = r & {b1, 4'hF};
	endfunction

	// Triangle approximation of a sinusoid, 12-bit signed
	function automatic logic signed [11:0] tri_wave(
			input logic [23:0] p);
		logic [11:0] f;
		f = {2'b00, p[21:12]};
		case (p[23:22])
			2'b00: tri_wave = f;
			2'b01: tri_wave = {2'b00, ~p[21:12]};
			2'b10: tri_wave = -f;
			default: tri_wave = -{2'b00, ~p[21:12]};
		endcase
	endfunction

	// ----------------------------------------
	// Pin and word toggle synchronisers
	// ----------------------------------------
	adp_sync2 #(
		.W(SYNC_W)
	) u_sync (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_d({i_temp_code, s.wtog, i_sdi, i_cs_b, i_sclk}),
		.o_q(sync_q)
	);
	assign sclk_s = sync_q[0];
	assign cs_s = sync_q[1];
	assign sdi_s = sync_q[2];
	assign wtog_s = sync_q[3];
	assign temp_s = sync_q[SYNC_W-1:4];

	// ----------------------------------------
	// Configuration port and register file
	// ----------------------------------------
	always_comb begin
		logic [23:0] fr;
		logic [4:0] d;
		logic [15:0] rv;
		logic bank1;
		next_q = q;
		fr = {q.sh, sdi_s};
		bank1 = q.rf[I_BANK][B_BANK1];
		next_q.sclk_d = sclk_s;
		next_q.wtog_d = wtog_s;
		// Read address decode on the eighth rising edge
		d = dec(fr[7:0], bank1);
		rv = d[4] ? q.rf[d[3:0]] : RST_REG;
		if (cs_s) begin
			next_q.bitc = '0;
			next_q.rd_act = 1'b0;
			next_q.sdo_oe = 1'b0;
			next_q.sdo = 1'b0;
		end else if (sclk_s && !q.sclk_d) begin
			next_q.sh = fr[22:0];
			next_q.bitc = q.bitc + 5'h01;
			if (q.bitc == SPI_ADDR_LAST && q.rf[I_RDEN][B_RD_EN]) begin
				next_q.rd_act = 1'b1;
				next_q.rd_sh = rv;
			end
			if (q.bitc == SPI_LAST) begin
				next_q.bitc = '0;
				next_q.rd_act = 1'b0;
				next_q.sdo_oe = 1'b0;
				d = dec(fr[23:16], bank1);
				// Read mode blocks writes except to its own control
				if (d[4] && d[3:0] != I_TRES &&
						(!q.rf[I_RDEN][B_RD_EN] || d[3:0] == I_RDEN)) begin
					next_q.rf[d[3:0]] = fr[15:0];
					next_q.cfg_tog = ~q.cfg_tog;
					// Temperature capture, independent of the link
					if (d[3:0] == I_TCTL && fr[15:0] == TEMP_LOAD) begin
						next_q.rf[I_TRES] = {6'h00, temp_s};
					end
				end
			end
		end else if (!sclk_s && q.sclk_d && q.rd_act) begin
			next_q.sdo = q.rd_sh[15]; // Result readback
			next_q.sdo_oe = 1'b1;
			next_q.rd_sh = {q.rd_sh[14:0], 1'b0};
		end
		next_q.ref_off = q.rf[I_REF][B_REF_OFF];
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			q <= '0;
			q.rf[I_LANE] <= RST_LANE;
		end else begin
			q <= next_q;
		end
	end

	// ----------------------------------------
	// Sample path, falling edge of sampling clock
	// ----------------------------------------
	// Mixer products carry four spare fraction bits
	localparam int MIX_SHIFT = 4;

	// Format, average, mix and hand each word over by toggle
	always_comb begin
		logic [15:0] x;
		logic signed [15:0] xs;
		logic signed [11:0] cw;
		logic signed [11:0] sw;
		logic signed [27:0] pi;
		logic signed [27:0] pq;
		logic signed [27:0] si;
		logic signed [27:0] sq;
		logic signed [27:0] so_i;
		logic signed [27:0] so_q;
		logic [15:0] code;
		logic [3:0] last;
		logic [2:0] sh;
		logic emit;
		next_s = s;
		x = i_adc_code;
		xs = $signed({~x[15], x[14:0]});
		cw = tri_wave(s.ph + OSC_QUARTER);
		sw = tri_wave(s.ph);
		pi = xs * cw;
		pq = -(xs * sw);
		si = '0;
		sq = '0;
		so_i = '0;
		so_q = '0;
		code = RST_REG;
		last = 4'hF >> (2'h3 - s.ratio);
		sh = {1'b0, s.ratio} + 3'h1;
		emit = 1'b0;

		// Configuration toggle, two stages before use
		next_s.cfg_s1 = q.cfg_tog;
		next_s.cfg_s2 = s.cfg_s1;
		next_s.cfg_d = s.cfg_s2;
		next_s.sync_d = i_sync_pulse_in;

		// Register values are settled once the toggle lands
		if (s.cfg_s2 != s.cfg_d) begin
			next_s.twos = q.rf[I_FMT][B_TWOS];
			next_s.avg_en = q.rf[I_FMT][B_AVG_EN];
			next_s.ddc_en = q.rf[I_FMT][B_DDC_EN];
			next_s.ratio = q.rf[I_FMT][F_RATIO_LO+1:F_RATIO_LO];
			next_s.freq = {q.rf[I_FRH], q.rf[I_PFS][15:8]} & OSC_MASK;
			next_s.phase0 = {q.rf[I_PFS][7:0], q.rf[I_PHL]} & OSC_MASK;
		end

		// Oscillator advances by the frequency word each sample
		next_s.ph = s.ph + s.freq;

		// Running sums, mixed products or plain codes
		if (s.ddc_en) begin
			si = s.acc_i + (pi >>> MIX_SHIFT);
			sq = s.acc_q + (pq >>> MIX_SHIFT);
		end else begin
			si = s.acc_i + $signed({12'h000, x});
			sq = '0;
		end

		// Emit each sample, or one average per window
		if (!s.avg_en) begin
			emit = 1'b1;
			so_i = si;
			so_q = sq;
			next_s.acc_i = '0;
			next_s.acc_q = '0;
			next_s.cnt = '0;
		end else if (s.cnt == last) begin
			emit = 1'b1;
			so_i = si >>> sh;
			so_q = sq >>> sh;
			next_s.acc_i = '0;
			next_s.acc_q = '0;
			next_s.cnt = '0;
		end else begin
			next_s.acc_i = si;
			next_s.acc_q = sq;
			next_s.cnt = s.cnt + 4'h1;
		end

		// Sync restarts the window and the oscillator phase
		if (i_sync_pulse_in && !s.sync_d) begin
			emit = 1'b0;
			next_s.acc_i = '0;
			next_s.acc_q = '0;
			next_s.cnt = '0;
			next_s.ph = s.phase0;
		end

		// Output coding of the averaged or plain code
		if (s.twos) begin
			code = {~so_i[15], so_i[14:0]};
		end else begin
			code = so_i[15:0];
		end

		// Word stays put until the next toggle
		if (emit) begin
			if (s.ddc_en) begin
				next_s.word = {so_i[23:0], so_q[23:0]};
			end else begin
				next_s.word = {code, 32'h00000000};
			end
			next_s.ddc_w = s.ddc_en;
			next_s.wtog = ~s.wtog;
		end
	end

	// Conversion results land on the falling sampling edge
	always_ff @(negedge i_smpl_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// Output link
	// ----------------------------------------
	// A new word starts a frame only while the framer is idle
	assign frm_start = (wtog_s != q.wtog_d) && !frm_busy;

	adp_framer u_frm (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_start(frm_start),
		.i_ddc(s.ddc_w),
		.i_w24(q.rf[I_LANE][F_LANE_HI:0] == LANE_W24),
		.i_sdr(q.rf[I_REF][B_RATE_SDR]),
		.i_word(s.word),
		.o_dclk(o_dclk),
		.o_dout(o_dout),
		.o_fclk(o_fclk),
		.o_busy(frm_busy)
	);

	// Port outputs straight from their registers
	assign o_sdo = q.sdo;
	assign o_sdo_oe = q.sdo_oe;
	assign o_internal_ref_off = q.ref_off;
endmodule

// *** include/adp_pkg.sv ***
/*
 * Shared constants for the converter output datapath: register offsets,
 * register indices, field positions, reset values and frame widths.
 * Assumes a 16-bit configuration register file and 8-bit addresses.
 */
package adp_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] A_RDEN = 8'h00;
	localparam logic [7:0] A_BANK = 8'h03;
	localparam logic [7:0] A_INIT = 8'h04;
	localparam logic [7:0] A_FMT = 8'h0D;
	localparam logic [7:0] A_LANE = 8'h12;
	localparam logic [7:0] A_LCF = 8'h1C;
	localparam logic [7:0] A_TCTL = 8'h90;
	localparam logic [7:0] A_TRES = 8'h91;
	localparam logic [7:0] A_PWR = 8'hC0;
	localparam logic [7:0] A_REF = 8'hC1;
	localparam logic [7:0] A_DINIT = 8'hC4;
	localparam logic [7:0] A_LCC = 8'hC5;
	localparam logic [7:0] A_LCE = 8'hFB;
	localparam logic [7:0] A_PHL = 8'hFC;
	localparam logic [7:0] A_PFS = 8'hFD;
	localparam logic [7:0] A_FRH = 8'hFE;
	// ----------------------------------------
	// Register file indices
	// ----------------------------------------
	localparam logic [3:0] I_RDEN = 4'h0;
	localparam logic [3:0] I_BANK = 4'h1;
	localparam logic [3:0] I_INIT = 4'h2;
	localparam logic [3:0] I_FMT = 4'h3;
	localparam logic [3:0] I_LANE = 4'h4;
	localparam logic [3:0] I_LCF = 4'h5;
	localparam logic [3:0] I_TCTL = 4'h6;
	localparam logic [3:0] I_TRES = 4'h7;
	localparam logic [3:0] I_PWR = 4'h8;
	localparam logic [3:0] I_REF = 4'h9;
	localparam logic [3:0] I_DINIT = 4'hA;
	localparam logic [3:0] I_LCC = 4'hB;
	localparam logic [3:0] I_LCE = 4'hC;
	localparam logic [3:0] I_PHL = 4'hD;
	localparam logic [3:0] I_PFS = 4'hE;
	localparam logic [3:0] I_FRH = 4'hF;
	// ----------------------------------------
	// Fields and values
	// ----------------------------------------
	localparam int B_RD_EN = 1;
	localparam int B_BANK1 = 0;
	localparam int B_BANK2 = 1;
	localparam int B_TWOS = 0;
	localparam int B_AVG_EN = 6;
	localparam int B_DDC_EN = 7;
	localparam int F_RATIO_LO = 2;
	localparam int F_RATIO_HI = 5;
	localparam int B_RATE_SDR = 8;
	localparam int B_REF_OFF = 2;
	localparam int F_LANE_HI = 2;
	localparam logic [2:0] LANE_W24 = 3'h2;
	localparam logic [15:0] TEMP_LOAD = 16'h4000;
	localparam int TEMP_W = 10;
	localparam logic [15:0] RST_REG = 16'h0000;
	localparam logic [15:0] RST_LANE = 16'h0002;
	localparam logic [23:0] OSC_MASK = 24'hFFFFF0;
	localparam logic [23:0] OSC_QUARTER = 24'h400000;
	localparam logic [4:0] SPI_LAST = 5'h17;
	localparam logic [4:0] SPI_ADDR_LAST = 5'h07;
	localparam logic [4:0] FRAME_W20 = 5'h14;
	localparam logic [4:0] FRAME_W24 = 5'h18;
	localparam int SYNC_W = 14;
endpackage

// *** verification/adp_host_rx.sv ***
/* Host receiver model: collects link frames, MSB first.
   Assumes the frame clock rises with each frame's first bit. */
module adp_host_rx (
	input wire logic i_dclk, // Bit clock
	input wire logic i_dout, // Link data
	input wire logic i_fclk, // Frame clock
	input wire logic i_w24, // 24-bit frames
	input wire logic i_ddr, // Both edges
	output logic [15:0] o_code, // Last sample
	output int o_cnt // Frames seen
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [23:0] sh = 24'h000000; // Shift register
	logic fq = 1'b0; // Frame clock at last bit
	int n = 0; // Bits this frame
	initial o_cnt = 0;
	initial o_code = 16'h0000;
	// ----
	// Bit capture just after each rising bit clock edge, and each falling edge when i_ddr is set
	// ----
	task automatic take();
		#1;
		n = (i_fclk && !fq) ? 1 : n + 1;
		fq = i_fclk;
		sh = {sh[22:0], i_dout};
		if (n == (i_w24 ? 24 : 20)) begin
			o_code = i_w24 ? sh[23:8] : sh[19:4];
			o_cnt++;
		end
	endtask
	always @(posedge i_dclk) take();
	always @(negedge i_dclk) if (i_ddr) take();
endmodule

// *** verification/adp_top_monitor.sv ***
/* Port checker for adp_top, bound to every instance.
   Assumes one system clock domain for all checks. */
module adp_top_mon (
	input wire logic i_clk, // Clock
	input wire logic i_rst_b, // Reset, active low
	input wire logic i_smpl_clk, // Sampling clock
	input wire logic i_sync_pulse_in, // Sync
	input wire logic [15:0] i_adc_code, // Code
	input wire logic [9:0] i_temp_code, // Sensor
	input wire logic i_cs_b, // Select, active low
	input wire logic i_sclk, // Port clock
	input wire logic i_sdi, // Port data in
	input wire logic o_sdo, // Port data out
	input wire logic o_sdo_oe, // Out enable
	input wire logic o_dclk, // Bit clock
	input wire logic o_dout, // Link data
	input wire logic o_fclk, // Frame clock
	input wire logic o_internal_ref_off // Reference off
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] idle; // Cycles since select low
	logic [4:0] edges; // Port clock rises in frame
	logic sclk_q; // Port clock, last cycle
	// ----
	// Port activity counters and checks
	// ----
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			idle <= 4'hF;
			edges <= 5'h00;
			sclk_q <= 1'b0;
		end else begin
			sclk_q <= i_sclk;
			idle <= !i_cs_b ? 4'h0 : idle + {3'h0, idle != 4'hF};
			edges <= idle == 4'hF ? 5'h00 : edges + {4'h0, i_sclk && !sclk_q};
		end
	end
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);
	property p_oe_idle; i_cs_b [*8] |-> !o_sdo_oe; endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("sdo idle");
	property p_oe_sel; $rose(o_sdo_oe) |-> !i_cs_b; endproperty
	a_oe_sel: assert property (p_oe_sel) else $error("sdo unsel");
	property p_oe_addr; o_sdo_oe |-> edges >= 5'h08; endproperty
	a_oe_addr: assert property (p_oe_addr) else $error("sdo early");
	property p_oe_rel; $rose(i_cs_b) |-> ##[1:6] !o_sdo_oe; endproperty
	a_oe_rel: assert property (p_oe_rel) else $error("sdo held");
	property p_ref_frm; $changed(o_internal_ref_off) |-> idle < 4'h8; endproperty
	a_ref_frm: assert property (p_ref_frm) else $error("ref moved");
	property p_ref_hold; i_cs_b [*8] |=> $stable(o_internal_ref_off); endproperty
	a_ref_hold: assert property (p_ref_hold) else $error("ref drift");
	property p_fc_gap; $rose(o_fclk) |=> (!$rose(o_fclk)) [*8]; endproperty
	a_fc_gap: assert property (p_fc_gap) else $error("short frame");
	property p_dc_run; $rose(o_fclk) |-> ##[0:8] $changed(o_dclk); endproperty
	a_dc_run: assert property (p_dc_run) else $error("no bit clk");
	c_read: cover property ($rose(o_sdo_oe));
	c_ref: cover property ($rose(o_internal_ref_off));
	c_frame: cover property ($rose(o_fclk));
endmodule
bind adp_top adp_top_mon u_mon (.i_clk(i_clk), .i_rst_b(i_rst_b),
	.i_smpl_clk(i_smpl_clk), .i_sync_pulse_in(i_sync_pulse_in),
	.i_adc_code(i_adc_code), .i_temp_code(i_temp_code), .i_cs_b(i_cs_b),
	.i_sclk(i_sclk), .i_sdi(i_sdi), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe),
	.o_dclk(o_dclk), .o_dout(o_dout), .o_fclk(o_fclk),
	.o_internal_ref_off(o_internal_ref_off));

// *** verification/adp_top_tb_top.sv ***
/* Bench for adp_top: port frames for registers, codes on the
   sampling side, frames checked by the host receiver model. */
module adp_top_tb_top
	import adp_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic i_smpl_clk = 1'b0;
	logic i_sync_pulse_in = 1'b0;
	logic [15:0] i_adc_code = 16'h0000;
	logic [9:0] i_temp_code = 10'h000;
	logic i_cs_b = 1'b1;
	logic i_sclk = 1'b0;
	logic i_sdi = 1'b0;
	logic o_sdo, o_sdo_oe, o_dclk, o_dout, o_fclk, o_internal_ref_off;
	logic w24 = 1'b1; // Receiver frame width
	logic ddr = 1'b0; // Receiver edge mode
	logic [15:0] rcode, rd;
	logic [15:0] tc [5] = '{16'h0000, 16'h7FFF, 16'hFFFF, 16'h0000,
		16'hFFFF};
	logic [15:0] te [5] = '{16'h0000, 16'h7FFF, 16'hFFFF, 16'h8000,
		16'h7FFF};
	int rcnt, c0, c1, f0, f1;
	int err_total = 0;
	int comparisons = 0;
	// System clock, then sampling clock with its own phase
	always #5 i_clk = ~i_clk;
	initial begin
		#13;
		forever #40 i_smpl_clk = ~i_smpl_clk;
	end
	adp_top dut (
		.i_clk(i_clk), .i_rst_b(i_rst_b), .i_smpl_clk(i_smpl_clk),
		.i_sync_pulse_in(i_sync_pulse_in), .i_adc_code(i_adc_code),
		.i_temp_code(i_temp_code), .i_cs_b(i_cs_b), .i_sclk(i_sclk),
		.i_sdi(i_sdi), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe),
		.o_dclk(o_dclk), .o_dout(o_dout), .o_fclk(o_fclk),
		.o_internal_ref_off(o_internal_ref_off)
	);
	adp_host_rx u_rx (.i_dclk(o_dclk), .i_dout(o_dout), .i_fclk(o_fclk),
		.i_w24(w24), .i_ddr(ddr), .o_code(rcode), .o_cnt(rcnt));
	// ----
	// Tasks
	// ----
	task automatic summarize();
		if (err_total == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// One 24-bit port frame; data out is taken before each rising edge
	task automatic xfer(input logic [7:0] a, input logic [15:0] d);
		logic [23:0] f;
		f = {a, d};
		@(posedge i_clk);
		i_cs_b <= 1'b0;
		for (int i = 23; i >= 0; i--) begin
			i_sdi <= f[i];
			repeat (10) @(posedge i_clk);
			rd = {rd[14:0], o_sdo};
			i_sclk <= 1'b1;
			repeat (10) @(posedge i_clk);
			i_sclk <= 1'b0;
		end
		repeat (4) @(posedge i_clk);
		i_cs_b <= 1'b1;
		repeat (30) @(posedge i_clk);
	endtask
	// Holds a code, lets old frames drain, checks a fresh frame
	task automatic link_chk(input logic [15:0] c, input logic [15:0] exp);
		@(posedge i_clk);
		i_adc_code <= c;
		repeat (600) @(posedge i_clk);
		c0 = rcnt;
		for (int k = 0; k < 3000 && rcnt < c0 + 2; k++) @(posedge i_clk);
		if (rcnt < c0 + 2) begin
			cmp(16'h0000, 16'h0001);
			summarize();
		end
		cmp(rcode, exp);
	endtask
	// Frames received over 100 sampling periods
	task automatic rate(output int f);
		c0 = rcnt;
		repeat (800) @(posedge i_clk);
		f = rcnt - c0;
	endtask
	initial begin
		repeat (12) @(posedge i_clk);
		i_rst_b <= 1'b1;
		repeat (4) @(posedge i_clk);
		cmp({15'h0000, o_internal_ref_off}, 16'h0000);
		xfer(A_INIT, 16'h0000);
		xfer(A_BANK, 16'h0001);
		xfer(A_RDEN, 16'h0002);
		xfer(A_LANE, 16'h0000);
		cmp(rd, RST_LANE);
		xfer(A_FMT, 16'h0000);
		cmp(rd, RST_REG);
		xfer(8'h55, 16'h0000);
		cmp(rd, 16'h0000);
		xfer(A_RDEN, 16'h0000);
		xfer(A_REF, 16'h0104);
		cmp({15'h0000, o_internal_ref_off}, 16'h0001);
		// Both code forms at the scale ends
		for (int i = 0; i < 5; i++) begin
			xfer(A_FMT, {15'h0000, i > 2});
			link_chk(tc[i], te[i]);
		end
		xfer(A_REF, 16'h0004);
		ddr <= 1'b1;
		link_chk(16'h1234, 16'h9234);
		// Temperature readout while frames keep flowing
		i_temp_code <= 10'h2A5;
		c1 = rcnt;
		xfer(A_TCTL, TEMP_LOAD);
		xfer(A_RDEN, 16'h0002);
		xfer(A_TRES, 16'h0000);
		cmp(rd, 16'h02A5);
		xfer(A_REF, 16'h0000);
		cmp(rd, 16'h0004);
		xfer(A_RDEN, 16'h0000);
		xfer(A_TCTL, 16'h0000);
		cmp(16'(rcnt > c1 + 4), 16'h0001);
		link_chk(16'h8001, 16'h0001);
		// Averaging by 16 after a sync pulse
		xfer(A_REF, 16'h0104);
		ddr <= 1'b0;
		xfer(A_FMT, 16'h0000);
		rate(f0);
		xfer(A_LCC, 16'h0200);
		xfer(A_PWR, 16'h0700);
		xfer(A_DINIT, 16'h0022);
		xfer(A_FMT, 16'h004C);
		i_sync_pulse_in <= 1'b1;
		repeat (16) @(posedge i_clk);
		i_sync_pulse_in <= 1'b0;
		link_chk(16'h4321, 16'h4321);
		rate(f1);
		cmp(16'(f1 >= 5 && f1 <= 7 && f0 > f1), 16'h0001);
		// 20-bit frames
		xfer(A_FMT, 16'h0000);
		xfer(A_INIT, 16'h000B);
		xfer(A_LANE, 16'h0000);
		xfer(A_REF, 16'h0105);
		xfer(A_LCC, 16'h000C);
		xfer(A_LCF, 16'h00C0);
		w24 <= 1'b0;
		link_chk(16'hA5C3, 16'hA5C3);
		summarize();
	end
endmodule
